// file: rtl/bssr_pkg.sv
package bssr_pkg;
    // Register geometry
    localparam int unsigned WIDTH     = 16;
    localparam int unsigned LAST_IDX  = WIDTH - 1;
    localparam logic [15:0] INIT_VAL  = 16'h0000;

    // Decoded operating mode
    typedef enum logic [1:0]
    {
        BSSR_HOLD   = 2'b00,
        BSSR_SLOAD  = 2'b01,
        BSSR_SOUT   = 2'b11,
        BSSR_PLOAD  = 2'b10
    } bssr_mode_t;

    // Mode decode from the three control levels
    function automatic bssr_mode_t bssr_decode(
        input logic selN,
        input logic readNotWrite,
        input logic modeSel
    );
        if (selN)
        begin
            return BSSR_HOLD;
        end
        else if (!readNotWrite)
        begin
            return BSSR_SLOAD;
        end
        else if (!modeSel)
        begin
            return BSSR_SOUT;
        end
        return BSSR_PLOAD;
    endfunction : bssr_decode
endpackage : bssr_pkg

// file: rtl/bssr_sync.sv
// Two-flop synchroniser for one pin-level input
module bssr_sync
    import bssr_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;  // First stage, read only by the second

    // Plain two-stage capture
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : bssr_sync

// file: rtl/bidir_serial_shift_register16.sv
// Notes on behaviour
// - Select high: hold contents, pin undriven.
// - Serial load: pin into first, shift up.
// - Serial out: drive last, recirculate to first.
// - Parallel load copies all sixteen inputs.
// - Parallel load keeps pin driven with last.
// - Direction high: mode picks output/parallel.
// - One pin is input or three-state output.
// - Sixteen stages, read only serially.
module bidir_serial_shift_register16
    import bssr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        unit_select_n,
    input  wire logic        read_not_write,
    input  wire logic        mode_select,
    input  wire logic        shift_clock_n,
    input  wire logic [15:0] parallel_inputs,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_oe
);
    // Synchronised pin levels; parallel bus also passes through two flops every clock,
    // the host holds it stable around the clock as for any set-up window
    logic        selNS;          // Synchronised select
    logic        rnwS;           // Synchronised direction
    logic        modeS;          // Synchronised mode
    logic        clkNS;          // Synchronised shift clock
    logic        serInS;         // Synchronised pin data
    logic [15:0] parS_q;         // Registered parallel bus
    logic [15:0] parMeta_q;      // First stage for the parallel bus
    logic        clkNPrev_q;     // Shift clock last cycle
    logic        fallEdge;       // Falling edge seen this cycle
    logic [15:0] shift_q;        // The sixteen stages
    bssr_mode_t  mode;           // Decoded mode

    // Next-state values, one comb block per concern
    logic [15:0] shift_d;        // Next value of the stages
    logic        serOe_d;        // Next pin enable
    logic        serOut_d;       // Next pin drive value

    // Every control pin is asynchronous to clk; all of them share the same
    // two-flop latency, so they stay aligned with the shift clock they qualify
    bssr_sync uSel
    (
        .clk  (clk),
        .nrst (nrst),
        .din  (unit_select_n),
        .dout (selNS)
    );
    bssr_sync uRnw
    (
        .clk  (clk),
        .nrst (nrst),
        .din  (read_not_write),
        .dout (rnwS)
    );
    bssr_sync uMode
    (
        .clk  (clk),
        .nrst (nrst),
        .din  (mode_select),
        .dout (modeS)
    );
    bssr_sync uClk
    (
        .clk  (clk),
        .nrst (nrst),
        .din  (shift_clock_n),
        .dout (clkNS)
    );
    bssr_sync uSer
    (
        .clk  (clk),
        .nrst (nrst),
        .din  (serial_in),
        .dout (serInS)
    );

    // Parallel bus synchroniser, kept wide here rather than sixteen instances.
    // Bits may land a clock apart if the bus moves near a clock; the host
    // keeps it steady well before the shift clock falls, so the word is whole
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            parMeta_q <= INIT_VAL;
            parS_q    <= INIT_VAL;
        end
        else
        begin
            parMeta_q <= parallel_inputs;
            parS_q    <= parMeta_q;
        end
    end

    // Edge detector on the synchronised shift clock
    // Resets to the synchroniser's own reset level: a mismatch here would
    // show a false falling edge on the first clock after reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clkNPrev_q <= 1'b0;  // Same level as the synchronised pin at reset
        end
        else
        begin
            clkNPrev_q <= clkNS;
        end
    end

    // A fall is seen two clocks after the pin moves: two synchroniser
    // stages, and this compare adds none. Levels shorter than one clock can be
    // missed, which bounds the usable shift rate.
    assign fallEdge = clkNPrev_q & ~clkNS;
    // Decode; direction low forces serial load whatever the mode
    // Controls reach here with the clock pin's latency, so a set-up time kept
    // at the pins is kept here too
    assign mode = bssr_decode(selNS, rnwS, modeS);

    // One step toward the last stage; both shifting modes use it, only the
    // bit fed into the first stage differs
    function automatic logic [15:0] bssr_step_up(
        input logic [15:0] stages,
        input logic        feedBit
    );
        return {stages[LAST_IDX-1:0], feedBit};
    endfunction : bssr_step_up

    // Next register value, moved only on a falling shift clock edge.
    // Hold is the default, so a missed case can never scramble the word.
    // Deselect releases safely only if the host keeps the clock low
    always_comb
    begin
        shift_d = shift_q;                                   // Hold unless clocked
        if (fallEdge)
        begin
            case (mode)
                BSSR_HOLD:
                begin
                    shift_d = shift_q;                       // Clock ignored
                end
                BSSR_SLOAD:
                begin
                    shift_d = bssr_step_up(shift_q, serInS); // Pin
                end
                BSSR_SOUT:
                begin
                    shift_d = bssr_step_up(shift_q, shift_q[LAST_IDX]); // Recirculate
                end
                BSSR_PLOAD:
                begin
                    shift_d = parS_q;                        // Whole word
                end
                default:
                begin
                    shift_d = shift_q;                       // Unreachable; hold
                end
            endcase
        end
    end

    // Stage storage; only the comb block above decides what moves
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_q <= INIT_VAL;
        end
        else
        begin
            shift_q <= shift_d;
        end
    end

    // Pin drive decode: driven in output and parallel modes, released otherwise
    always_comb
    begin
        serOe_d  = 1'b0;
        serOut_d = 1'b0;
        case (mode)
            BSSR_SOUT:
            begin
                serOe_d  = 1'b1;                   // Data out
                serOut_d = shift_q[LAST_IDX];      // Last stage shown
            end
            BSSR_PLOAD:
            begin
                serOe_d  = 1'b1;                   // Stays active
                serOut_d = shift_q[LAST_IDX];      // Last stage shown
            end
            BSSR_SLOAD:
            begin
                serOe_d  = 1'b0;                   // Host owns the pin
                serOut_d = 1'b0;
            end
            BSSR_HOLD:
            begin
                serOe_d  = 1'b0;                   // High impedance
                serOut_d = 1'b0;
            end
            default:
            begin
                serOe_d  = 1'b0;                   // Unreachable; stay off the pin
                serOut_d = 1'b0;
            end
        endcase
    end

    // Output flops; registered, so the pin trails the stage it shows by one
    // clock, the price of keeping every top output straight from a flop
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serial_out <= 1'b0;
            serial_oe  <= 1'b0;
        end
        else
        begin
            serial_out <= serOut_d;
            serial_oe  <= serOe_d;
        end
    end
endmodule : bidir_serial_shift_register16

// file: sim/bssr_asserts.sv
// Pin-level checks on the top module's outputs
module bssr_asserts
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic unit_select_n,
    input wire logic read_not_write,
    input wire logic serial_out,
    input wire logic serial_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_hiz; $rose(unit_select_n) |-> ##[1:5] !serial_oe; endproperty
    a_hiz: assert property (p_hiz) else $error("pin kept driving");
    property p_off; unit_select_n[*6] |-> !serial_oe; endproperty
    a_off: assert property (p_off) else $error("driven while idle");
    property p_hold; unit_select_n[*8] |-> $stable(serial_out); endproperty
    a_hold: assert property (p_hold) else $error("idle output moved");
    property p_wr; (!unit_select_n && !read_not_write)[*6] |-> !serial_oe; endproperty
    a_wr: assert property (p_wr) else $error("driven in load");
    property p_rd; (!unit_select_n && read_not_write)[*6] |-> serial_oe; endproperty
    a_rd: assert property (p_rd) else $error("not driven in read");
    property p_up; $rose(serial_oe) |-> !unit_select_n && read_not_write; endproperty
    a_up: assert property (p_up) else $error("bad enable");
    property p_dn; $fell(serial_oe) |-> unit_select_n || !read_not_write; endproperty
    a_dn: assert property (p_dn) else $error("bad disable");
    property p_z0; !serial_oe |-> !serial_out; endproperty
    a_z0: assert property (p_z0) else $error("value while off");
    cover property ($rose(serial_oe));
    cover property ($fell(serial_oe));
    cover property (serial_oe && $changed(serial_out));
endmodule : bssr_asserts
bind bidir_serial_shift_register16 bssr_asserts u_bssr_asserts (.clk(clk), .nrst(nrst),
    .unit_select_n(unit_select_n), .read_not_write(read_not_write),
    .serial_out(serial_out), .serial_oe(serial_oe));

// file: sim/bssr_host.sv
// Host end of the shared pin; resolves the wire level
module bssr_host
(
    input  wire logic clk,
    input  wire logic serial_out,
    input  wire logic serial_oe,
    input  wire logic hostDrive,
    input  wire logic hostBit,
    output logic      pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic floatQ = 1'b0; // Released line wanders so stale data never passes
    always_ff @(posedge clk) floatQ <= ~floatQ;
    // Host drives only while the device is off the pin
    assign pinLevel = serial_oe ? serial_out : (hostDrive ? hostBit : floatQ);
endmodule : bssr_host

// file: sim/bidir_serial_shift_register16_test.sv
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module bidir_serial_shift_register16_test import bssr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, selN = 1, rnw = 0, mode = 0, sck = 0, drv = 0, hb = 0;
    logic [15:0] pin = 16'h0000, expQ = 16'h0000;
    logic so, oe, pinLv;
    int cmp_count = 0, n_errors = 0;
    always #5 clk = ~clk;
    bidir_serial_shift_register16 u_bidir_serial_shift_register16 (.clk(clk), .nrst(nrst),
        .unit_select_n(selN), .read_not_write(rnw), .mode_select(mode), .shift_clock_n(sck),
        .parallel_inputs(pin), .serial_in(pinLv), .serial_out(so), .serial_oe(oe));
    bssr_host u_bssr_host (.clk(clk), .serial_out(so), .serial_oe(oe), .hostDrive(drv),
        .hostBit(hb), .pinLevel(pinLv));
    function automatic logic [15:0] nxt(logic s, r, m, b, logic [15:0] p, q);
        if (s) return q;
        if (!r) return {q[14:0], b};
        if (!m) return {q[14:0], q[15]};
        return p;
    endfunction : nxt
    // Controls move only while the clock is low, so deselect never clocks
    task op(input logic s, r, m, b, input logic [15:0] p);
        @(posedge clk);
        selN <= s;
        rnw <= r;
        mode <= m;
        drv <= 1'b0;
        hb <= b;
        pin <= p;
        repeat (5) @(posedge clk);
        // Device lets go of the pin three clocks after the controls move
        drv <= !s && !r;
        sck <= 1;
        repeat (4) @(posedge clk);
        sck <= 0;
        repeat (8) @(posedge clk);
        expQ = nxt(s, r, m, b, p, expQ);
        `CHK("oe", logic'(!s && r), oe)
        `CHK("out", logic'(!s && r && expQ[15]), so)
    endtask : op
    task complete_run;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // Tests need about 17 us; the limit leaves ample room before a hang counts
    initial
    begin
        #60us;
        n_errors++;
        complete_run();
    end
    initial
    begin
        void'($urandom(14460));
        repeat (10) @(posedge clk);
        nrst <= 1;
        for (int i = 0; i < 16; i++) op(0, 0, 1, 1'(16'ha5c3 >> i), 16'hffff);
        for (int i = 0; i < 17; i++) op(0, 1, i == 0, 0, 16'h3c96);
        $display("test corner done");
        repeat (60) op($urandom % 4 == 0, 1'($urandom), 1'($urandom), 1'($urandom),
            16'($urandom));
        $display("test random done");
        complete_run();
    end
endmodule : bidir_serial_shift_register16_test
